//--- ssx_exec.sv
// execute stage for shift, store, swap, subtract, watchdog-off and exclusive-or
// assumes the fetch unit supplies the decoded operation, the operand word and the mask word with start
// Contract
// - right shift by count, zero fill
// - carry takes last bit shifted out
// - zero count uses low nibble of register one
// - masked store writes only mask-one bits
// - zero mask uses register one; both zero: nothing
// - byte store writes low byte, keeps other half
// - left byte unless odd index or register
// - byte register store: right half, left ones
// - word store copies whole register
// - subtract operand from register, operand kept
// - subtract sets carry and overflow else clears
// - base register swaps with operand
// - general register swaps with operand
// - watchdog off when privileged
// - unprivileged watchdog off traps to vector 13
// - byte xor sign-extends byte into register
// - word xor into register
// - stores, swaps, xors keep carry and overflow
// - operand may be memory, immediate or register
`timescale 1ns/10ps
`include "ssx_map.svh"
module ssx_exec #(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire ssx_pkg::ssx_op_t  op,
  input  wire ssx_pkg::ssx_sel_t general_reg_select,
  input  wire ssx_pkg::ssx_sel_t base_reg_select,
  input  wire ssx_pkg::ssx_sel_t byte_register_select,
  input  wire ssx_pkg::ssx_cnt_t shift_count,
  input  wire ssx_pkg::ssx_word_t mask_word,
  input  wire ssx_pkg::ssx_ea_t  ea_kind,
  input  wire logic              ea_index_odd,
  input  wire ssx_pkg::ssx_sel_t ea_reg_select,
  input  wire ssx_pkg::ssx_word_t ea_word,
  input  wire ssx_pkg::ssx_word_t status_word,
  input  wire logic              priv_bit,
  input  wire logic              load_en,
  input  wire logic [1:0]        load_file,
  input  wire ssx_pkg::ssx_sel_t load_sel,
  input  wire ssx_pkg::ssx_word_t load_data,
  output logic                   ready,
  output logic                   done,
  output logic                   mem_wr_en,
  output ssx_pkg::ssx_word_t     mem_wr_data,
  output logic                   carry_flag,
  output logic                   overflow_indicator,
  output logic                   watchdog_enabled,
  output logic                   trap_req,
  output ssx_pkg::ssx_byte_t     trap_vector
);
  import ssx_pkg::*;

  ssx_rf_if rf ();

  ssx_state_t state_q, state_d;
  ssx_op_t    op_q, op_d;
  ssx_ea_t    ea_q, ea_d;
  ssx_sel_t   gsel_q, gsel_d, bsel_q, bsel_d, msel_q, msel_d, esel_q, esel_d;
  ssx_cnt_t   cnt_q, cnt_d;
  logic       odd_q, odd_d, priv_q, priv_d;
  ssx_word_t  mask_q, mask_d, eaw_q, eaw_d, stat_q, stat_d;
  logic       carry_q, carry_d, ovf_q, ovf_d, wdog_q, wdog_d;
  logic       done_q, done_d, mwr_q, mwr_d, trap_q, trap_d;
  ssx_word_t  mdata_q, mdata_d;
  ssx_byte_t  tvec_q, tvec_d;

  // execute-cycle datapath values
  ssx_word_t  rn, r1, eav, eff_mask, shifted, sext, res_gen, res_ea;
  ssx_byte_t  opnd_byte;
  ssx_cnt_t   eff_cnt;
  logic [`SSX_WORD_MSB+1:0] diff;
  logic       right_byte, wr_gen, wr_base, wr_ea, exec;

  ssx_regfile #(
    .DEPTH (DEPTH)
  ) u_regfile (
    .sys_clk (sys_clk),
    .rst     (rst),
    .rf      (rf.rf)
  );

  // register read selects come from the latched instruction
  assign rf.gen_a_sel  = gsel_q;
  assign rf.gen_b_sel  = esel_q;
  assign rf.base_a_sel = bsel_q;
  assign rf.base_b_sel = esel_q;
  assign rf.byte_sel   = msel_q;
  assign exec          = (state_q == st_exec);

  // operand selection and arithmetic
  always_comb
  begin
    rn         = rf.gen_a_data;
    r1         = rf.gen_one_data;
    // register operand reads the general file, or the base file for the base swap
    eav        = (ea_q != ea_reg) ? eaw_q : (op_q == op_base_xchg) ? rf.base_b_data : rf.gen_b_data;
    right_byte = (ea_q == ea_reg) || (ea_q == ea_mem_idx && odd_q);
    opnd_byte  = right_byte ? eav[`SSX_RB_HI:`SSX_RB_LO] : eav[`SSX_LB_HI:`SSX_LB_LO];
    sext       = {{(`SSX_WORD_MSB-`SSX_BYTE_MSB){opnd_byte[`SSX_BYTE_MSB]}}, opnd_byte};
    eff_cnt    = (cnt_q != `SSX_ZERO_CNT) ? cnt_q : r1[`SSX_CNT_MSB:0];
    shifted    = rn >> eff_cnt;
    eff_mask   = (mask_q != `SSX_ZERO_WORD) ? mask_q : r1;
    diff       = {1'b0, rn} - {1'b0, eav};
  end

  // result routing per operation
  always_comb
  begin
    res_gen = rn;
    res_ea  = eav;
    wr_gen  = 1'b0;
    wr_base = 1'b0;
    wr_ea   = 1'b0;
    carry_d = carry_q;
    ovf_d   = ovf_q;
    wdog_d  = wdog_q;
    trap_d  = 1'b0;
    tvec_d  = tvec_q;
    if (exec)
    begin
      unique case (op_q)
        op_shift_right:
        begin
          res_gen = shifted;
          wr_gen  = 1'b1;
          if (eff_cnt != `SSX_ZERO_CNT)
            carry_d = rn[eff_cnt - `SSX_ONE_CNT];
        end
        op_masked_store:
        begin
          res_ea = (rn & eff_mask) | (eav & ~eff_mask);
          wr_ea  = (eff_mask != `SSX_ZERO_WORD);
        end
        op_byte_store:
        begin
          res_ea = right_byte ? {eav[`SSX_LB_HI:`SSX_LB_LO], rn[`SSX_RB_HI:`SSX_RB_LO]}
                              : {rn[`SSX_RB_HI:`SSX_RB_LO], eav[`SSX_RB_HI:`SSX_RB_LO]};
          wr_ea  = 1'b1;
        end
        op_byte_reg_store:
        begin
          res_ea = {`SSX_ONES_BYTE, rf.byte_data};
          wr_ea  = 1'b1;
        end
        op_word_store:
        begin
          res_ea = rn;
          wr_ea  = 1'b1;
        end
        op_status_store:
        begin
          res_ea = stat_q;
          wr_ea  = 1'b1;
        end
        op_sub:
        begin
          res_gen = diff[`SSX_WORD_MSB:0];
          wr_gen  = 1'b1;
          carry_d = diff[`SSX_WORD_MSB+1];
          ovf_d   = (rn[`SSX_WORD_MSB] ^ eav[`SSX_WORD_MSB]) & (diff[`SSX_WORD_MSB] ^ rn[`SSX_WORD_MSB]);
        end
        op_base_xchg:
        begin
          res_gen = eav;
          res_ea  = rf.base_a_data;
          wr_base = 1'b1;
          wr_ea   = 1'b1;
        end
        op_gen_xchg:
        begin
          res_gen = eav;
          res_ea  = rn;
          wr_gen  = 1'b1;
          wr_ea   = 1'b1;
        end
        op_wdog_off:
        begin
          if (priv_q)
            wdog_d = 1'b0;
          else
          begin
            trap_d = 1'b1;
            tvec_d = `SSX_TRAP_PRIV;
          end
        end
        op_byte_xor:
        begin
          res_gen = rn ^ sext;
          wr_gen  = 1'b1;
        end
        op_word_xor:
        begin
          res_gen = rn ^ eav;
          wr_gen  = 1'b1;
        end
        default:
        begin
          wr_gen = 1'b0;
        end
      endcase
    end
  end

  // register file writes: port 0 for the named register or preload, port 1 for a register operand
  always_comb
  begin
    rf.gen_wr0_en    = wr_gen || (load_en && state_q == st_idle && load_file == `SSX_FILE_GEN);
    rf.gen_wr0_sel   = exec ? gsel_q : load_sel;
    rf.gen_wr0_data  = exec ? res_gen : load_data;
    rf.base_wr0_en   = wr_base || (load_en && state_q == st_idle && load_file == `SSX_FILE_BASE);
    rf.base_wr0_sel  = exec ? bsel_q : load_sel;
    rf.base_wr0_data = exec ? res_gen : load_data;
    rf.byte_wr_en    = load_en && state_q == st_idle && load_file == `SSX_FILE_BYTE;
    rf.byte_wr_sel   = load_sel;
    rf.byte_wr_data  = load_data[`SSX_RB_HI:`SSX_RB_LO];
    rf.gen_wr1_en    = wr_ea && ea_q == ea_reg && op_q != op_base_xchg;
    rf.gen_wr1_sel   = esel_q;
    rf.gen_wr1_data  = res_ea;
    rf.base_wr1_en   = wr_ea && ea_q == ea_reg && op_q == op_base_xchg;
    rf.base_wr1_sel  = esel_q;
    rf.base_wr1_data = res_ea;
    mwr_d            = wr_ea && ea_q != ea_reg;
    mdata_d          = mwr_d ? res_ea : mdata_q;
    done_d           = exec;
  end

  // sequencer and instruction latch
  always_comb
  begin
    state_d = state_q;
    op_d    = op_q;
    ea_d    = ea_q;
    gsel_d  = gsel_q;
    bsel_d  = bsel_q;
    msel_d  = msel_q;
    esel_d  = esel_q;
    cnt_d   = cnt_q;
    odd_d   = odd_q;
    priv_d  = priv_q;
    mask_d  = mask_q;
    eaw_d   = eaw_q;
    stat_d  = stat_q;
    unique case (state_q)
      st_idle:
        if (start)
        begin
          state_d = st_read;
          op_d    = op;
          ea_d    = ea_kind;
          gsel_d  = general_reg_select;
          bsel_d  = base_reg_select;
          msel_d  = byte_register_select;
          esel_d  = ea_reg_select;
          cnt_d   = shift_count;
          odd_d   = ea_index_odd;
          priv_d  = priv_bit;
          mask_d  = mask_word;
          eaw_d   = ea_word;
          stat_d  = status_word;
        end
      st_read: state_d = st_exec;
      st_exec: state_d = st_idle;
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      op_q    <= op_word_store;
      ea_q    <= ea_mem;
      gsel_q  <= `SSX_SEL_ZERO;
      bsel_q  <= `SSX_SEL_ZERO;
      msel_q  <= `SSX_SEL_ZERO;
      esel_q  <= `SSX_SEL_ZERO;
      cnt_q   <= `SSX_ZERO_CNT;
      odd_q   <= 1'b0;
      priv_q  <= 1'b0;
      mask_q  <= `SSX_ZERO_WORD;
      eaw_q   <= `SSX_ZERO_WORD;
      stat_q  <= `SSX_ZERO_WORD;
      carry_q <= `SSX_FLAG_RST;
      ovf_q   <= `SSX_FLAG_RST;
      wdog_q  <= `SSX_WDOG_RST;
      done_q  <= 1'b0;
      mwr_q   <= 1'b0;
      mdata_q <= `SSX_ZERO_WORD;
      trap_q  <= 1'b0;
      tvec_q  <= `SSX_ZERO_BYTE;
    end
    else
    begin
      state_q <= state_d;
      op_q    <= op_d;
      ea_q    <= ea_d;
      gsel_q  <= gsel_d;
      bsel_q  <= bsel_d;
      msel_q  <= msel_d;
      esel_q  <= esel_d;
      cnt_q   <= cnt_d;
      odd_q   <= odd_d;
      priv_q  <= priv_d;
      mask_q  <= mask_d;
      eaw_q   <= eaw_d;
      stat_q  <= stat_d;
      carry_q <= carry_d;
      ovf_q   <= ovf_d;
      wdog_q  <= wdog_d;
      done_q  <= done_d;
      mwr_q   <= mwr_d;
      mdata_q <= mdata_d;
      trap_q  <= trap_d;
      tvec_q  <= tvec_d;
    end
  end

  // outputs
  assign ready              = (state_q == st_idle);
  assign done               = done_q;
  assign mem_wr_en          = mwr_q;
  assign mem_wr_data        = mdata_q;
  assign carry_flag         = carry_q;
  assign overflow_indicator = ovf_q;
  assign watchdog_enabled   = wdog_q;
  assign trap_req           = trap_q;
  assign trap_vector        = tvec_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_done_latency: assert property (ready && start |-> ##3 done)
    else $error("done not three cycles after start");
  chk_shift_fill: assert property (exec && op_q == op_shift_right && eff_cnt != `SSX_ZERO_CNT
    |-> res_gen[`SSX_WORD_MSB] == 1'b0 && (res_gen << eff_cnt) == (rn & ~((`SSX_ZERO_WORD + 1 << eff_cnt) - 1)))
    else $error("shift result not zero filled");
  chk_shift_carry: assert property (exec && op_q == op_shift_right && eff_cnt != `SSX_ZERO_CNT
    |=> carry_flag == $past(rn[eff_cnt - `SSX_ONE_CNT]))
    else $error("shift carry wrong");
  chk_shift_r1: assert property (exec && cnt_q == `SSX_ZERO_CNT |-> eff_cnt == r1[`SSX_CNT_MSB:0])
    else $error("zero count not taken from register one");
  chk_mask_merge: assert property (mem_wr_en && op_q == op_masked_store
    |-> (($past(eav) ^ mem_wr_data) & ~$past(eff_mask)) == `SSX_ZERO_WORD)
    else $error("masked store changed unmasked bits");
  chk_mask_noop: assert property (exec && op_q == op_masked_store && eff_mask == `SSX_ZERO_WORD
    |=> !mem_wr_en && !$past(rf.gen_wr1_en))
    else $error("zero mask store wrote");
  chk_byte_keep: assert property (mem_wr_en && op_q == op_byte_store && !$past(right_byte)
    |-> mem_wr_data[`SSX_RB_HI:`SSX_RB_LO] == $past(eav[`SSX_RB_HI:`SSX_RB_LO]))
    else $error("byte store disturbed other half");
  chk_byte_ones: assert property (mem_wr_en && op_q == op_byte_reg_store
    |-> mem_wr_data[`SSX_LB_HI:`SSX_LB_LO] == `SSX_ONES_BYTE)
    else $error("byte register store left half not ones");
  chk_sub_flags: assert property (exec && op_q == op_sub |=> carry_flag == $past(rn < eav))
    else $error("subtract carry wrong");
  chk_flags_kept: assert property (exec && op_q != op_sub && op_q != op_shift_right
    |=> $stable(carry_flag) && $stable(overflow_indicator))
    else $error("flags changed by store, swap or xor");
  chk_swap_pair: assert property (exec && op_q == op_gen_xchg |-> res_gen == eav && res_ea == rn)
    else $error("register swap not symmetric");
  chk_xor_word: assert property (exec && op_q == op_word_xor |-> (res_gen ^ rn) == eav)
    else $error("word xor wrong");
  chk_priv_trap: assert property (exec && op_q == op_wdog_off && !priv_q
    |=> trap_req && trap_vector == `SSX_TRAP_PRIV && $stable(watchdog_enabled))
    else $error("unprivileged watchdog off did not trap");

  cov_sub: cover property (exec && op_q == op_sub ##1 overflow_indicator);
  cov_trap: cover property (trap_req);
  cov_mask_noop: cover property (exec && op_q == op_masked_store && eff_mask == `SSX_ZERO_WORD);
endmodule : ssx_exec

//--- ssx_map.svh
// constants of the store, swap, logic and shift execute block
// assumes it is included by bare name from the package and the design files
`ifndef SSX_MAP_SVH
`define SSX_MAP_SVH
`define SSX_WORD_MSB    15
`define SSX_BYTE_MSB    7
`define SSX_LB_HI       15
`define SSX_LB_LO       8
`define SSX_RB_HI       7
`define SSX_RB_LO       0
`define SSX_CNT_MSB     3
`define SSX_SEL_MSB     2
`define SSX_ZERO_WORD   16'h0000
`define SSX_ZERO_BYTE   8'h00
`define SSX_ZERO_CNT    4'h0
`define SSX_ONE_CNT     4'h1
`define SSX_ONES_BYTE   8'hFF
`define SSX_R1_IDX      3'h1
`define SSX_SEL_ZERO    3'h0
`define SSX_TRAP_PRIV   8'h0D
`define SSX_WDOG_RST    1'b1
`define SSX_FLAG_RST    1'b0
`define SSX_FILE_GEN    2'h0
`define SSX_FILE_BASE   2'h1
`define SSX_FILE_BYTE   2'h2
`endif

//--- ssx_mem_model.sv
// word of main memory at the far side of the execute block
// assumes one clock shared with the block; the bench may preload the word
`timescale 1ns/10ps
module ssx_mem_model
  import ssx_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               wr_en,
  input  wire ssx_pkg::ssx_word_t wr_data,
  input  wire logic               pre_en,
  input  wire ssx_pkg::ssx_word_t pre_data,
  output ssx_pkg::ssx_word_t      word_q
);
  // block writes win over a preload in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
      word_q <= wr_data;
    else if (pre_en)
      word_q <= pre_data;
  end
endmodule : ssx_mem_model

//--- ssx_pkg.sv
// types shared by the execute block, its register file and their carrier
// assumes the constant header sits in the same folder
`include "ssx_map.svh"
package ssx_pkg;
  typedef logic [`SSX_WORD_MSB:0] ssx_word_t;
  typedef logic [`SSX_BYTE_MSB:0] ssx_byte_t;
  typedef logic [`SSX_SEL_MSB:0]  ssx_sel_t;
  typedef logic [`SSX_CNT_MSB:0]  ssx_cnt_t;
  // operations executed by the block
  typedef enum logic [3:0] {
    op_shift_right, op_masked_store, op_byte_store, op_byte_reg_store,
    op_word_store, op_status_store, op_sub, op_base_xchg,
    op_gen_xchg, op_wdog_off, op_byte_xor, op_word_xor
  } ssx_op_t;
  // kind of effective-address operand
  typedef enum logic [1:0] {ea_mem, ea_mem_idx, ea_imm, ea_reg} ssx_ea_t;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_read = 3'b010,
    st_exec = 3'b100
  } ssx_state_t;
endpackage : ssx_pkg

//--- ssx_regfile.sv
// general, base and byte register files with registered read data
// assumes selects are stable the cycle before the data is used
`timescale 1ns/10ps
module ssx_regfile #(
  parameter int unsigned DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  ssx_rf_if.rf     rf
);
  import ssx_pkg::*;
  ssx_word_t gen_q  [DEPTH];
  ssx_word_t gen_d  [DEPTH];
  ssx_word_t base_q [DEPTH];
  ssx_word_t base_d [DEPTH];
  ssx_byte_t byte_q [DEPTH];
  ssx_byte_t byte_d [DEPTH];
  ssx_word_t gen_a_q, gen_a_d, gen_b_q, gen_b_d, gen_one_q, gen_one_d;
  ssx_word_t base_a_q, base_a_d, base_b_q, base_b_d;
  ssx_byte_t byte_rd_q, byte_rd_d;

  // per-entry next value, port 1 wins over port 0 on the same entry
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    assign gen_d[i]  = (rf.gen_wr1_en && rf.gen_wr1_sel == ssx_sel_t'(i)) ? rf.gen_wr1_data :
                       (rf.gen_wr0_en && rf.gen_wr0_sel == ssx_sel_t'(i)) ? rf.gen_wr0_data : gen_q[i];
    assign base_d[i] = (rf.base_wr1_en && rf.base_wr1_sel == ssx_sel_t'(i)) ? rf.base_wr1_data :
                       (rf.base_wr0_en && rf.base_wr0_sel == ssx_sel_t'(i)) ? rf.base_wr0_data : base_q[i];
    assign byte_d[i] = (rf.byte_wr_en && rf.byte_wr_sel == ssx_sel_t'(i)) ? rf.byte_wr_data : byte_q[i];
  end

  // read muxes feeding the read registers
  always_comb
  begin
    gen_a_d   = gen_q[rf.gen_a_sel];
    gen_b_d   = gen_q[rf.gen_b_sel];
    gen_one_d = gen_q[`SSX_R1_IDX];
    base_a_d  = base_q[rf.base_a_sel];
    base_b_d  = base_q[rf.base_b_sel];
    byte_rd_d = byte_q[rf.byte_sel];
  end

  // storage and read registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gen_q     <= '{default: `SSX_ZERO_WORD};
      base_q    <= '{default: `SSX_ZERO_WORD};
      byte_q    <= '{default: `SSX_ZERO_BYTE};
      gen_a_q   <= `SSX_ZERO_WORD;
      gen_b_q   <= `SSX_ZERO_WORD;
      gen_one_q <= `SSX_ZERO_WORD;
      base_a_q  <= `SSX_ZERO_WORD;
      base_b_q  <= `SSX_ZERO_WORD;
      byte_rd_q <= `SSX_ZERO_BYTE;
    end
    else
    begin
      gen_q     <= gen_d;
      base_q    <= base_d;
      byte_q    <= byte_d;
      gen_a_q   <= gen_a_d;
      gen_b_q   <= gen_b_d;
      gen_one_q <= gen_one_d;
      base_a_q  <= base_a_d;
      base_b_q  <= base_b_d;
      byte_rd_q <= byte_rd_d;
    end
  end

  assign rf.gen_a_data   = gen_a_q;
  assign rf.gen_b_data   = gen_b_q;
  assign rf.gen_one_data = gen_one_q;
  assign rf.base_a_data  = base_a_q;
  assign rf.base_b_data  = base_b_q;
  assign rf.byte_data    = byte_rd_q;
endmodule : ssx_regfile

//--- ssx_rf_if.sv
// carrier between the execute sequencer and its register file
// assumes both ends share one clock
`timescale 1ns/10ps
interface ssx_rf_if;
  import ssx_pkg::*;
  ssx_sel_t  gen_a_sel;
  ssx_sel_t  gen_b_sel;
  ssx_sel_t  base_a_sel;
  ssx_sel_t  base_b_sel;
  ssx_sel_t  byte_sel;
  ssx_word_t gen_a_data;
  ssx_word_t gen_b_data;
  ssx_word_t gen_one_data;
  ssx_word_t base_a_data;
  ssx_word_t base_b_data;
  ssx_byte_t byte_data;
  logic      gen_wr0_en;
  ssx_sel_t  gen_wr0_sel;
  ssx_word_t gen_wr0_data;
  logic      gen_wr1_en;
  ssx_sel_t  gen_wr1_sel;
  ssx_word_t gen_wr1_data;
  logic      base_wr0_en;
  ssx_sel_t  base_wr0_sel;
  ssx_word_t base_wr0_data;
  logic      base_wr1_en;
  ssx_sel_t  base_wr1_sel;
  ssx_word_t base_wr1_data;
  logic      byte_wr_en;
  ssx_sel_t  byte_wr_sel;
  ssx_byte_t byte_wr_data;
  modport exec (
    output gen_a_sel, gen_b_sel, base_a_sel, base_b_sel, byte_sel,
    output gen_wr0_en, gen_wr0_sel, gen_wr0_data, gen_wr1_en, gen_wr1_sel, gen_wr1_data,
    output base_wr0_en, base_wr0_sel, base_wr0_data, base_wr1_en, base_wr1_sel, base_wr1_data,
    output byte_wr_en, byte_wr_sel, byte_wr_data,
    input  gen_a_data, gen_b_data, gen_one_data, base_a_data, base_b_data, byte_data
  );
  modport rf (
    input  gen_a_sel, gen_b_sel, base_a_sel, base_b_sel, byte_sel,
    input  gen_wr0_en, gen_wr0_sel, gen_wr0_data, gen_wr1_en, gen_wr1_sel, gen_wr1_data,
    input  base_wr0_en, base_wr0_sel, base_wr0_data, base_wr1_en, base_wr1_sel, base_wr1_data,
    input  byte_wr_en, byte_wr_sel, byte_wr_data,
    output gen_a_data, gen_b_data, gen_one_data, base_a_data, base_b_data, byte_data
  );
endinterface : ssx_rf_if

//--- store_swap_logic_shift_exec_bench.sv
// self-checking bench for the execute block with a memory word model
// assumes the block takes start at an idle edge and pulses done three edges later
`timescale 1ns/10ps
module store_swap_logic_shift_exec_bench;
  import ssx_pkg::*;
  logic       sys_clk, rst, start, ea_index_odd, priv_bit, load_en, pre_en;
  ssx_op_t    op;
  ssx_sel_t   general_reg_select, base_reg_select, byte_register_select, ea_reg_select, load_sel;
  ssx_cnt_t   shift_count;
  ssx_word_t  mask_word, ea_word, status_word, load_data, mem_wr_data, got;
  ssx_ea_t    ea_kind;
  logic [1:0] load_file;
  logic       ready, done, mem_wr_en, carry_flag, overflow_indicator, watchdog_enabled, trap_req;
  logic       seen_wr, seen_trap;
  ssx_byte_t  trap_vector;
  int         fail_count = 0;
  int         checks_done = 0;
  ssx_exec dut (.sys_clk(sys_clk), .rst(rst), .start(start), .op(op),
    .general_reg_select(general_reg_select), .base_reg_select(base_reg_select),
    .byte_register_select(byte_register_select), .shift_count(shift_count), .mask_word(mask_word),
    .ea_kind(ea_kind), .ea_index_odd(ea_index_odd), .ea_reg_select(ea_reg_select), .ea_word(ea_word),
    .status_word(status_word), .priv_bit(priv_bit), .load_en(load_en), .load_file(load_file),
    .load_sel(load_sel), .load_data(load_data), .ready(ready), .done(done), .mem_wr_en(mem_wr_en),
    .mem_wr_data(mem_wr_data), .carry_flag(carry_flag), .overflow_indicator(overflow_indicator),
    .watchdog_enabled(watchdog_enabled), .trap_req(trap_req), .trap_vector(trap_vector));
  ssx_mem_model mem (.sys_clk(sys_clk), .wr_en(mem_wr_en), .wr_data(mem_wr_data), .pre_en(pre_en),
    .pre_data(load_data), .word_q(ea_word));
  // compare and count
  task automatic chk(input string what, input ssx_word_t seen, input ssx_word_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // preload a register file (0 gen, 1 base, 2 byte) or the memory word (3)
  task automatic ld(input logic [1:0] f, input ssx_sel_t s, input ssx_word_t d);
    @(negedge sys_clk);
    load_en = (f != 2'h3);
    pre_en = (f == 2'h3);
    load_file = f;
    load_sel = s;
    load_data = d;
    @(negedge sys_clk);
    load_en = 1'b0;
    pre_en = 1'b0;
  endtask : ld
  // one operation; captures the pulses of the done cycle
  task automatic go(input ssx_op_t o, input ssx_sel_t r, input ssx_ea_t k, input logic odd);
    int n;
    @(negedge sys_clk);
    start = 1'b1;
    op = o;
    general_reg_select = r;
    ea_kind = k;
    ea_index_odd = odd;
    @(negedge sys_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("done", {15'h0, done}, 16'h0001);
    seen_wr = mem_wr_en;
    seen_trap = trap_req;
    got = mem_wr_data;
  endtask : go
  // verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // shift by field, then by the register one nibble
  task automatic t_shift();
    ld(2'h0, 3'h2, 16'h8005);
    shift_count = 4'h3;
    go(op_shift_right, 3'h2, ea_reg, 1'b0);
    chk("shift carry", {15'h0, carry_flag}, 16'h0001);
    go(op_word_store, 3'h2, ea_mem, 1'b0);
    chk("shift result", got, 16'h1000);
    ld(2'h0, 3'h1, 16'h0004);
    ld(2'h0, 3'h3, 16'h00F0);
    shift_count = 4'h0;
    go(op_shift_right, 3'h3, ea_reg, 1'b0);
    chk("r1 carry", {15'h0, carry_flag}, 16'h0000);
    go(op_word_store, 3'h3, ea_mem, 1'b0);
    chk("r1 shift", got, 16'h000F);
  endtask : t_shift
  // masked, byte and status stores
  task automatic t_store();
    ld(2'h3, 3'h0, 16'h1234);
    ld(2'h0, 3'h5, 16'hABCD);
    mask_word = 16'h1111;
    go(op_masked_store, 3'h5, ea_mem, 1'b0);
    chk("masked", got, 16'h0325);
    ld(2'h3, 3'h0, 16'h1234);
    ld(2'h0, 3'h1, 16'h00FF);
    mask_word = 16'h0000;
    go(op_masked_store, 3'h5, ea_mem, 1'b0);
    chk("mask r1", got, 16'h12CD);
    ld(2'h0, 3'h1, 16'h0000);
    go(op_masked_store, 3'h5, ea_mem, 1'b0);
    chk("mask none", {15'h0, seen_wr}, 16'h0000);
    ld(2'h3, 3'h0, 16'h1234);
    go(op_byte_store, 3'h5, ea_mem, 1'b0);
    chk("byte left", got, 16'hCD34);
    ld(2'h3, 3'h0, 16'h1234);
    go(op_byte_store, 3'h5, ea_mem_idx, 1'b1);
    chk("byte odd", got, 16'h12CD);
    go(op_byte_store, 3'h5, ea_imm, 1'b0);
    chk("byte imm", got, 16'hCDCD);
    ld(2'h2, 3'h2, 16'h005A);
    byte_register_select = 3'h2;
    go(op_byte_reg_store, 3'h0, ea_mem, 1'b0);
    chk("byte reg", got, 16'hFF5A);
    status_word = 16'hA5A5;
    go(op_status_store, 3'h0, ea_mem, 1'b0);
    chk("status", got, 16'hA5A5);
  endtask : t_store
  // subtract with borrow and with overflow; flags then survive a store
  task automatic t_sub();
    ld(2'h0, 3'h4, 16'h0001);
    ld(2'h3, 3'h0, 16'hFFFF);
    go(op_sub, 3'h4, ea_mem, 1'b0);
    chk("sub wr", {15'h0, seen_wr}, 16'h0000);
    chk("sub flags", {14'h0, carry_flag, overflow_indicator}, 16'h0002);
    go(op_word_store, 3'h4, ea_mem, 1'b0);
    chk("sub diff", got, 16'h0002);
    ld(2'h0, 3'h4, 16'h8000);
    ld(2'h3, 3'h0, 16'h0001);
    chk("flags kept", {14'h0, carry_flag, overflow_indicator}, 16'h0002);
    ld(2'h0, 3'h4, 16'h8000);
    ld(2'h3, 3'h0, 16'h0001);
    go(op_sub, 3'h4, ea_mem, 1'b0);
    chk("sub ovf", {14'h0, carry_flag, overflow_indicator}, 16'h0001);
    go(op_word_store, 3'h4, ea_mem, 1'b0);
    chk("sub ovf diff", got, 16'h7FFF);
  endtask : t_sub
  // swaps, xors and the privileged watchdog-off
  task automatic t_misc();
    ld(2'h0, 3'h6, 16'h1111);
    ld(2'h3, 3'h0, 16'h2222);
    go(op_gen_xchg, 3'h6, ea_mem, 1'b0);
    chk("gen swap mem", got, 16'h1111);
    go(op_word_store, 3'h6, ea_mem, 1'b0);
    chk("gen swap reg", got, 16'h2222);
    ld(2'h1, 3'h3, 16'h3333);
    ld(2'h3, 3'h0, 16'h4444);
    base_reg_select = 3'h3;
    go(op_base_xchg, 3'h0, ea_mem, 1'b0);
    chk("base swap mem", got, 16'h3333);
    go(op_base_xchg, 3'h0, ea_mem, 1'b0);
    chk("base swap reg", got, 16'h4444);
    ld(2'h0, 3'h7, 16'hFFFF);
    ld(2'h3, 3'h0, 16'h8812);
    go(op_byte_xor, 3'h7, ea_mem, 1'b0);
    go(op_word_store, 3'h7, ea_mem, 1'b0);
    chk("byte xor", got, 16'h0077);
    ld(2'h3, 3'h0, 16'h8888);
    go(op_word_xor, 3'h7, ea_mem, 1'b0);
    go(op_word_store, 3'h7, ea_mem, 1'b0);
    chk("word xor", got, 16'h88FF);
    priv_bit = 1'b0;
    go(op_wdog_off, 3'h0, ea_mem, 1'b0);
    chk("trap", {15'h0, seen_trap}, 16'h0001);
    chk("trap vec", {8'h0, trap_vector}, 16'h000D);
    chk("wdog kept", {15'h0, watchdog_enabled}, 16'h0001);
    priv_bit = 1'b1;
    go(op_wdog_off, 3'h0, ea_mem, 1'b0);
    chk("no trap", {15'h0, seen_trap}, 16'h0000);
    chk("wdog off", {15'h0, watchdog_enabled}, 16'h0000);
  endtask : t_misc
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // reset, then the scenarios
  initial
  begin
    rst = 1'b1;
    start = 1'b0;
    load_en = 1'b0;
    pre_en = 1'b0;
    op = op_word_store;
    general_reg_select = 3'h0;
    base_reg_select = 3'h0;
    byte_register_select = 3'h0;
    ea_reg_select = 3'h0;
    shift_count = 4'h0;
    mask_word = 16'h0000;
    status_word = 16'h0000;
    priv_bit = 1'b0;
    ea_kind = ea_mem;
    ea_index_odd = 1'b0;
    load_file = 2'h0;
    load_sel = 3'h0;
    load_data = 16'h0000;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    chk("reset wdog", {15'h0, watchdog_enabled}, 16'h0001);
    t_shift();
    t_store();
    t_sub();
    t_misc();
    end_of_test();
  end
  // watchdog on the whole run
  initial
  begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule : store_swap_logic_shift_exec_bench
